/* File: core/vcs_consts.svh */
// What this block does
// - Lock blocks writes to limit, grids, map
// - Map pointer stays writable while locked
// - Lock bit D1: 0 unlocked, 1 locked
// - Blink bit: 0 slow 1s, 1 fast 0.5s
// - Blink period counts multiplex clock edges
// - Font bit D3 picks 14 or 16 segment
// - Font 0 is 14/7, 1 is 16/7
// - Sync bit restarts blink and scan
// - Sync clears blink counters at select rise
// - Clear bit D5 erases segment data
// - Clear hits 0x20-0x7f at select rise
// - Mode bit D6 picks 96/2 or 48/1
// - Config read returns live blink phase D7
// - Select low framing, data sampled clock rise
// - Ignore clock and data while deselected
// - Serial out routed to pump or logic outputs
// - Serial out always driven, never floating
// - Word is address byte then data byte
// - Host sends msb first, msb high reads
// - Chain delay 15.5 serial clock cycles
// - Host sends 16 times n clocks
// - All-zero word is a no-op
// - Output zero low after reset feeds no-ops
`ifndef VCS_CONSTS_SVH
`define VCS_CONSTS_SVH

// ----------------------------------------
// command addresses
// ----------------------------------------
`define VCS_ADDR_NOOP 7'h00
`define VCS_ADDR_GRIDS 7'h03
`define VCS_ADDR_CFG 7'h04
`define VCS_ADDR_MAP_DATA 7'h06
`define VCS_ADDR_MAP_PTR 7'h07
`define VCS_ADDR_PORT_CFG 7'h0a
`define VCS_ADDR_SHIFT_LIMIT 7'h0e
`define VCS_ADDR_MEM_LO 7'h20
`define VCS_MEM_DEPTH 96
`define VCS_MAP_DEPTH 8

// ----------------------------------------
// field positions
// ----------------------------------------
`define VCS_CMD_RD_BIT 15
`define VCS_CFG_SHDN 0
`define VCS_CFG_LOCK 1
`define VCS_CFG_FAST 2
`define VCS_CFG_FONT 3
`define VCS_CFG_SYNC 4
`define VCS_CFG_CLEAR 5
`define VCS_CFG_MODE 6
`define VCS_CFG_PHASE 7
`define VCS_PCFG_SEL_LSB 0
`define VCS_PCFG_P0_LVL 2
`define VCS_PCFG_P1_LVL 3
`define VCS_PCFG_PUMP_LVL 4
`define VCS_SEL_NONE 2'h0
`define VCS_SEL_PUMP 2'h1
`define VCS_SEL_OUT_ZERO 2'h2
`define VCS_SEL_OUT_ONE 2'h3

// ----------------------------------------
// reset values
// ----------------------------------------
`define VCS_CFG_RESET 8'h00
`define VCS_PCFG_RESET 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define VCS_CLK_PERIOD_NS 100
`define VCS_SCLK_HALF_NS 400
`define VCS_SCLK_HALF_CNT (`VCS_SCLK_HALF_NS / `VCS_CLK_PERIOD_NS)
`define VCS_MUX_CLK_KHZ 4000
`define VCS_BLINK_SLOW_MS 1000
`define VCS_BLINK_FAST_MS 500
`define VCS_BLINK_SLOW_CNT (`VCS_MUX_CLK_KHZ * `VCS_BLINK_SLOW_MS)
`define VCS_BLINK_FAST_CNT (`VCS_MUX_CLK_KHZ * `VCS_BLINK_FAST_MS)
`define VCS_WORD_BITS 16

`endif

/* File: core/vcs_pkg.sv */
package vcs_pkg;
   // one serial command word, msb first on the wire
   typedef struct packed {
      logic rd;
      logic [6:0] addr;
      logic [7:0] data;
   } vcs_cmd_type;

   // host frame sequencer
   typedef enum logic [2:0] {
      VCS_H_IDLE,
      VCS_H_LOW,
      VCS_H_HIGH,
      VCS_H_CS_UP,
      VCS_H_TAIL
   } vcs_hstate_type;

   typedef logic [1:0] vcs_dout_sel_type;
endpackage

/* File: core/vcs_link_if.sv */
`timescale 1ns/100ps
interface vcs_link_if;
   logic sclk;
   logic cs_n;
   logic din;
   logic pump;
   logic logic_output_zero;
   logic logic_output_one;

   modport device (
      input sclk, cs_n, din,
      output pump, logic_output_zero, logic_output_one
   );

   modport host (
      output sclk, cs_n, din,
      input pump, logic_output_zero, logic_output_one
   );
endinterface

/* File: core/vcs_device.sv */
`timescale 1ns/100ps
`include "vcs_consts.svh"
module vcs_device #(
   parameter int unsigned BLINK_SLOW_CNT = `VCS_BLINK_SLOW_CNT,
   parameter int unsigned BLINK_FAST_CNT = `VCS_BLINK_FAST_CNT
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // multiplex oscillator, asynchronous
   input wire logic i_mux_clk,
   // serial link
   vcs_link_if.device link,
   // configuration state
   output logic o_shutdown_n,
   output logic o_lock,
   output logic o_blink_fast,
   output logic o_font_16seg,
   output logic o_mode_two_per_grid,
   output logic o_blink_first_half,
   output logic o_scan_restart,
   output logic [7:0] o_shift_limit,
   output logic [7:0] o_grids,
   output vcs_pkg::vcs_dout_sel_type o_dout_sel
);
   import vcs_pkg::*;

   localparam int CW = $clog2(BLINK_SLOW_CNT + 1);

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [2:0] sclk_q;
   logic [2:0] csn_q;
   logic [1:0] din_q;
   logic [2:0] mux_q;

   // stage 0 feeds stage 1 only; edges are taken between stages 1 and 2
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         sclk_q <= 3'h0;
         csn_q <= 3'h7;
         din_q <= 2'h0;
         mux_q <= 3'h0;
      end else begin
         sclk_q <= {sclk_q[1:0], link.sclk};
         csn_q <= {csn_q[1:0], link.cs_n};
         din_q <= {din_q[0], link.din};
         mux_q <= {mux_q[1:0], i_mux_clk};
      end
   end

   wire selected = ~csn_q[1];
   wire sclk_rise = sclk_q[1] & ~sclk_q[2] & selected;
   wire sclk_fall = ~sclk_q[1] & sclk_q[2] & selected;
   wire cs_rise = csn_q[1] & ~csn_q[2];
   wire cs_fall = ~csn_q[1] & csn_q[2];
   wire mux_tick = mux_q[1] & ~mux_q[2];

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   logic [15:0] shreg;
   logic [7:0] cfg;
   logic [7:0] port_cfg;
   logic [7:0] shift_limit;
   logic [7:0] grids;
   logic [7:0] map_ptr;
   logic [7:0] map_mem [0:`VCS_MAP_DEPTH-1];
   logic [7:0] disp_mem [0:`VCS_MEM_DEPTH-1];
   logic [CW-1:0] blink_cnt;
   logic blink_first;
   logic scan_restart;
   logic dout_bit;

   // the shift register itself is the latch: it shifts only while selected and loads read data as select rises
   wire vcs_cmd_type cmd = shreg;
   wire cmd_wr = cs_rise & ~cmd.rd;
   wire cmd_rd = cs_rise & cmd.rd;
   wire locked = cfg[`VCS_CFG_LOCK];
   // address 0x00 matches nothing below, so the zero word does nothing
   wire hit_cfg = cmd.addr == `VCS_ADDR_CFG;
   wire hit_grids = cmd.addr == `VCS_ADDR_GRIDS;
   wire hit_limit = cmd.addr == `VCS_ADDR_SHIFT_LIMIT;
   wire hit_map = cmd.addr == `VCS_ADDR_MAP_DATA;
   wire hit_ptr = cmd.addr == `VCS_ADDR_MAP_PTR;
   wire hit_pcfg = cmd.addr == `VCS_ADDR_PORT_CFG;
   wire hit_mem = cmd.addr >= `VCS_ADDR_MEM_LO;
   wire [6:0] mem_idx = 7'(cmd.addr - `VCS_ADDR_MEM_LO);
   wire [2:0] map_idx = map_ptr[2:0];

   // locked writes vanish with no flag and no effect on framing
   wire wr_cfg = cmd_wr & hit_cfg;
   wire wr_grids = cmd_wr & hit_grids & ~locked;
   wire wr_limit = cmd_wr & hit_limit & ~locked;
   wire wr_map = cmd_wr & hit_map & ~locked;
   wire wr_ptr = cmd_wr & hit_ptr;
   wire wr_pcfg = cmd_wr & hit_pcfg;
   wire wr_mem = cmd_wr & hit_mem;
   wire clr_mem = wr_cfg & cmd.data[`VCS_CFG_CLEAR];
   wire blink_sync = wr_cfg & cmd.data[`VCS_CFG_SYNC];

   // ----------------------------------------
   // read-back selection
   // ----------------------------------------
   wire [7:0] cfg_view = {blink_first, cfg[6:0]};
   wire [7:0] mem_view = hit_mem ? disp_mem[mem_idx] : 8'h00;
   wire [7:0] rd_data =
      hit_cfg ? cfg_view :
      hit_grids ? grids :
      hit_limit ? shift_limit :
      hit_map ? map_mem[map_idx] :
      hit_ptr ? map_ptr :
      hit_pcfg ? port_cfg :
      mem_view;

   // ----------------------------------------
   // serial shift path
   // ----------------------------------------
   // read data replaces the low byte so the next frame shifts it out
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         shreg <= 16'h0000;
      end else if (sclk_rise) begin
         shreg <= {shreg[14:0], din_q[1]};
      end else if (cmd_rd) begin
         shreg <= {shreg[15:8], rd_data};
      end
   end

   // out bit moves on the falling edge: 15 rises in, half a cycle out
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         dout_bit <= 1'b0;
      end else if (sclk_fall || cs_fall) begin
         dout_bit <= shreg[15];
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         cfg <= `VCS_CFG_RESET;
         port_cfg <= `VCS_PCFG_RESET;
         shift_limit <= 8'h00;
         grids <= 8'h00;
         map_ptr <= 8'h00;
      end else begin
         if (wr_cfg) begin
            cfg <= cmd.data;
         end
         if (wr_pcfg) begin
            port_cfg <= cmd.data;
         end
         if (wr_limit) begin
            shift_limit <= cmd.data;
         end
         if (wr_grids) begin
            grids <= cmd.data;
         end
         if (wr_ptr) begin
            map_ptr <= cmd.data;
         end
      end
   end

   // map contents kept as plain storage, no reset needed
   always_ff @(posedge i_clk) begin
      if (wr_map) begin
         map_mem[map_idx] <= cmd.data;
      end
   end

   // one flop group per display byte so the clear hits all in one edge
   genvar gi;
   generate
      for (gi = 0; gi < `VCS_MEM_DEPTH; gi = gi + 1) begin : g_mem
         always_ff @(posedge i_clk) begin
            if (i_sys_rst || clr_mem) begin
               disp_mem[gi] <= 8'h00;
            end else if (wr_mem && mem_idx == 7'(gi)) begin
               disp_mem[gi] <= cmd.data;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // blink timing
   // ----------------------------------------
   // counting oscillator edges keeps the period tied to its frequency
   wire [CW-1:0] blink_half =
      cfg[`VCS_CFG_FAST] ? CW'(BLINK_FAST_CNT - 1) : CW'(BLINK_SLOW_CNT - 1);
   wire blink_wrap = blink_cnt >= blink_half;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst || blink_sync) begin
         blink_cnt <= '0;
         blink_first <= 1'b1;
      end else if (mux_tick) begin
         if (blink_wrap) begin
            blink_cnt <= '0;
            blink_first <= ~blink_first;
         end else begin
            blink_cnt <= blink_cnt + CW'(1);
         end
      end
   end

   // one pulse to the scan logic; a one-off flicker is accepted
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         scan_restart <= 1'b0;
      end else begin
         scan_restart <= blink_sync;
      end
   end

   // ----------------------------------------
   // output pins
   // ----------------------------------------
   wire [1:0] dsel = port_cfg[`VCS_PCFG_SEL_LSB +: 2];
   // every pin is a plain push-pull level, even while deselected
   wire next_pump = (dsel == `VCS_SEL_PUMP) ? dout_bit : port_cfg[`VCS_PCFG_PUMP_LVL];
   wire next_out_zero =
      (dsel == `VCS_SEL_OUT_ZERO) ? dout_bit : port_cfg[`VCS_PCFG_P0_LVL];
   wire next_out_one =
      (dsel == `VCS_SEL_OUT_ONE) ? dout_bit : port_cfg[`VCS_PCFG_P1_LVL];

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         link.pump <= 1'b0;
         link.logic_output_zero <= 1'b0;
         link.logic_output_one <= 1'b0;
      end else begin
         link.pump <= next_pump;
         link.logic_output_zero <= next_out_zero;
         link.logic_output_one <= next_out_one;
      end
   end

   assign o_shutdown_n = cfg[`VCS_CFG_SHDN];
   assign o_lock = cfg[`VCS_CFG_LOCK];
   assign o_blink_fast = cfg[`VCS_CFG_FAST];
   assign o_font_16seg = cfg[`VCS_CFG_FONT];
   assign o_mode_two_per_grid = cfg[`VCS_CFG_MODE];
   assign o_blink_first_half = blink_first;
   assign o_scan_restart = scan_restart;
   assign o_shift_limit = shift_limit;
   assign o_grids = grids;
   assign o_dout_sel = dsel;
endmodule

/* File: core/vcs_host.sv */
`timescale 1ns/100ps
`include "vcs_consts.svh"
module vcs_host #(
   parameter int unsigned CHAIN_LEN = 1
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // user request
   input wire logic i_start,
   input wire logic [`VCS_WORD_BITS*CHAIN_LEN-1:0] i_wdata,
   input wire vcs_pkg::vcs_dout_sel_type i_dout_sel,
   // user answer
   output logic o_busy,
   output logic o_done,
   output logic [`VCS_WORD_BITS*CHAIN_LEN-1:0] o_rdata,
   // serial link
   vcs_link_if.host link
);
   import vcs_pkg::*;

   localparam int NB = `VCS_WORD_BITS * CHAIN_LEN;
   localparam int BW = $clog2(NB + 1);
   localparam logic [3:0] HALF_LAST = 4'(`VCS_SCLK_HALF_CNT - 1);

   // ----------------------------------------
   // returned data pin
   // ----------------------------------------
   logic [1:0] dout_q;
   wire dout_pin =
      (i_dout_sel == `VCS_SEL_PUMP) ? link.pump :
      (i_dout_sel == `VCS_SEL_OUT_ONE) ? link.logic_output_one : link.logic_output_zero;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         dout_q <= 2'h0;
      end else begin
         dout_q <= {dout_q[0], dout_pin};
      end
   end

   // ----------------------------------------
   // frame sequencer
   // ----------------------------------------
   vcs_hstate_type state;
   logic [3:0] cnt;
   logic [BW-1:0] bits;
   logic [NB-1:0] tx;
   logic [NB-1:0] rx;
   wire half_done = cnt == HALF_LAST;
   wire last_bit = bits == BW'(NB - 1);

   // sclk is divided from i_clk here, so it is no second domain
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state <= VCS_H_IDLE;
         cnt <= 4'h0;
         bits <= '0;
         tx <= '0;
         rx <= '0;
         o_rdata <= '0;
         o_done <= 1'b0;
         link.sclk <= 1'b0;
         link.cs_n <= 1'b1;
         link.din <= 1'b0;
      end else begin
         o_done <= 1'b0;
         cnt <= half_done ? 4'h0 : cnt + 4'h1;
         case (state)
            VCS_H_IDLE: begin
               cnt <= 4'h0;
               if (i_start) begin
                  tx <= i_wdata;
                  bits <= '0;
                  link.cs_n <= 1'b0;
                  link.din <= i_wdata[NB-1];
                  state <= VCS_H_LOW;
               end
            end
            VCS_H_LOW: begin
               if (half_done) begin
                  link.sclk <= 1'b1;
                  state <= VCS_H_HIGH;
               end
            end
            VCS_H_HIGH: begin
               // sample late in the high phase; device output moves after the fall
               if (half_done) begin
                  rx <= {rx[NB-2:0], dout_q[1]};
                  bits <= bits + BW'(1);
                  if (last_bit) begin
                     link.cs_n <= 1'b1;
                     state <= VCS_H_CS_UP;
                  end else begin
                     link.sclk <= 1'b0;
                     link.din <= tx[NB-2];
                     tx <= {tx[NB-2:0], 1'b0};
                     state <= VCS_H_LOW;
                  end
               end
            end
            VCS_H_CS_UP: begin
               if (half_done) begin
                  link.sclk <= 1'b0;
                  state <= VCS_H_TAIL;
               end
            end
            VCS_H_TAIL: begin
               // gap keeps the device's commit clear of the next frame
               if (half_done) begin
                  o_rdata <= rx;
                  o_done <= 1'b1;
                  state <= VCS_H_IDLE;
               end
            end
            default: begin
               state <= VCS_H_IDLE;
            end
         endcase
      end
   end

   assign o_busy = state != VCS_H_IDLE;
endmodule

/* File: test/vcs_link_sva.sv */
`timescale 1ns/100ps
module vcs_link_sva (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // link wires
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_din,
   input wire logic i_pump,
   input wire logic i_logic_output_zero,
   input wire logic i_logic_output_one
);
   logic [7:0] rises;
   logic booted;
   wire [2:0] pins = {i_pump, i_logic_output_zero, i_logic_output_one};
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   // ------
   // helpers
   // ------
   // sclk rises counted per frame, cleared as select falls
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || $fell(i_cs_n))
         rises <= 8'h00;
      else if ($rose(i_sclk) && !i_cs_n)
         rises <= rises + 8'h01;
   end
   // first frame ends the boot window where every pin must sit low
   always_ff @(posedge i_clk) begin
      if (i_sys_rst)
         booted <= 1'b0;
      else if ($rose(i_cs_n))
         booted <= 1'b1;
   end
   chk_sclk_high_min: assert property ($rose(i_sclk) |-> i_sclk [*4])
      else $error("sclk high half too short");
   chk_sclk_low_min: assert property ($fell(i_sclk) && !i_cs_n |-> !i_sclk [*4])
      else $error("sclk low half too short");
   chk_din_hold: assert property ($rose(i_sclk) |-> $stable(i_din) [*3])
      else $error("din moved near sclk rise");
   chk_pins_stand: assert property ($rose(i_sclk) && !i_cs_n |=> $stable(pins) [*3])
      else $error("serial out moved while sclk high");
   chk_idle_hold: assert property (i_cs_n [*8] |-> $stable(pins))
      else $error("pins moved while deselected");
   chk_sixteen_clk: assert property ($rose(i_cs_n) |-> rises == 8'h10)
      else $error("frame without sixteen clocks");
   chk_cs_rise_high: assert property ($rose(i_cs_n) |-> i_sclk ##[1:6] !i_sclk)
      else $error("select rose with sclk low");
   chk_cs_fall_low: assert property ($fell(i_cs_n) |-> !i_sclk [*4])
      else $error("select fell with sclk high");
   chk_boot_low: assert property (!booted |-> pins == 3'h0)
      else $error("pin high before first frame");
   cov_frame: cover property ($rose(i_cs_n) && rises == 8'h10);
   cov_read: cover property ($fell(i_cs_n) ##4 $rose(i_sclk) && i_din);
   cov_gap: cover property (i_cs_n [*8] ##1 !i_cs_n);
endmodule

/* File: test/vfd_config_and_serial_port_bench.sv */
`timescale 1ns/100ps
`include "vcs_consts.svh"
module vfd_config_and_serial_port_bench;
   import vcs_pkg::*;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_mux_clk = 1'b0;
   logic i_start = 1'b0;
   logic [15:0] i_wdata = 16'h0000;
   vcs_dout_sel_type i_dout_sel = 2'h2;
   logic o_busy, o_done, o_shutdown_n, o_lock, o_blink_fast, o_font_16seg;
   logic o_mode_two_per_grid, o_blink_first_half, o_scan_restart;
   logic [15:0] o_rdata;
   logic [7:0] o_shift_limit, o_grids;
   vcs_dout_sel_type o_dout_sel;
   int err_count = 0;
   int compares = 0;
   int seed = 73073;
   int restarts = 0;
   int i;
   logic [15:0] r;
   logic [7:0] g, s, c;
   vcs_link_if link ();
   always #50 i_clk = ~i_clk;
   // scan restart is a single-cycle pulse, so it is counted, not sampled
   always @(negedge i_clk) if (o_scan_restart === 1'b1) restarts++;
   vcs_host #(.CHAIN_LEN(1)) vcs_host_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_start(i_start), .i_wdata(i_wdata), .i_dout_sel(i_dout_sel), .o_busy(o_busy),
      .o_done(o_done), .o_rdata(o_rdata), .link(link.host));
   vcs_device #(.BLINK_SLOW_CNT(8), .BLINK_FAST_CNT(4)) vcs_device_inst (.i_clk(i_clk),
      .i_sys_rst(i_sys_rst), .i_mux_clk(i_mux_clk), .link(link.device),
      .o_shutdown_n(o_shutdown_n), .o_lock(o_lock), .o_blink_fast(o_blink_fast),
      .o_font_16seg(o_font_16seg), .o_mode_two_per_grid(o_mode_two_per_grid),
      .o_blink_first_half(o_blink_first_half), .o_scan_restart(o_scan_restart),
      .o_shift_limit(o_shift_limit), .o_grids(o_grids), .o_dout_sel(o_dout_sel));
   vcs_link_sva vcs_link_sva_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_sclk(link.sclk), .i_cs_n(link.cs_n), .i_din(link.din), .i_pump(link.pump),
      .i_logic_output_zero(link.logic_output_zero),
      .i_logic_output_one(link.logic_output_one));
   // ------
   // tasks
   // ------
   task automatic summarize();
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one whole frame; the commit lands a few clocks after select rises
   task automatic xfer(input logic [15:0] w);
      int n;
      @(negedge i_clk);
      i_wdata = w;
      i_start = 1'b1;
      @(negedge i_clk);
      i_start = 1'b0;
      check_byte({7'h00, o_busy}, 8'h01);
      for (n = 0; n < 400 && o_done !== 1'b1; n++) @(negedge i_clk);
      if (o_done !== 1'b1) begin
         err_count++;
         $display("mismatch at %0t: no done", $time);
         summarize();
      end
      check_byte({7'h00, o_busy}, 8'h00);
      r = o_rdata;
      repeat (6) @(negedge i_clk);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      xfer({1'b0, a, d});
   endtask
   // read answer leaves in the following frame, address byte first
   task automatic rd_check(input logic [6:0] a, input logic [7:0] exp);
      xfer({1'b1, a, 8'h00});
      xfer(16'h0000);
      check_byte({1'b0, r[14:8]}, {1'b0, a});
      check_byte(r[7:0], exp);
   endtask
   // oscillator is gated so blink phase is known exactly
   task automatic mux_pulses(input int n);
      repeat (n) begin
         #185 i_mux_clk = 1'b1;
         #185 i_mux_clk = 1'b0;
      end
      repeat (6) @(negedge i_clk);
   endtask
   // ------
   // sequence
   // ------
   initial begin
      repeat (3) @(negedge i_clk);
      i_sys_rst = 1'b0;
      check_byte({7'h00, o_blink_first_half}, 8'h01);
      check_byte({7'h00, o_lock}, 8'h00);
      wr(`VCS_ADDR_PORT_CFG, 8'h02);
      check_byte({6'h00, o_dout_sel}, 8'h02);
      for (i = 0; i < 4; i++) begin
         g = 8'($random(seed));
         s = 8'($random(seed));
         c = 8'($random(seed)) & 8'hcd;
         wr(`VCS_ADDR_GRIDS, g);
         wr(`VCS_ADDR_SHIFT_LIMIT, s);
         wr(`VCS_ADDR_CFG, c);
         check_byte(o_grids, g);
         check_byte(o_shift_limit, s);
         check_byte({7'h00, o_blink_fast}, {7'h00, c[2]});
         check_byte({7'h00, o_font_16seg}, {7'h00, c[3]});
         check_byte({7'h00, o_mode_two_per_grid}, {7'h00, c[6]});
         check_byte({7'h00, o_shutdown_n}, {7'h00, c[0]});
         rd_check(`VCS_ADDR_GRIDS, g);
         rd_check(`VCS_ADDR_CFG, {1'b1, c[6:0]});
      end
      rd_check(7'h01, 8'h00);
      xfer(16'h0000);
      check_byte(o_grids, g);
      wr(7'h20, 8'ha5);
      wr(7'h7f, 8'h5a);
      rd_check(7'h20, 8'ha5);
      rd_check(7'h7f, 8'h5a);
      wr(`VCS_ADDR_CFG, c | 8'h20);
      rd_check(7'h20, 8'h00);
      rd_check(7'h7f, 8'h00);
      // each pin takes the serial output in turn, the others show their levels
      wr(`VCS_ADDR_PORT_CFG, 8'h0d);
      i_dout_sel = `VCS_SEL_PUMP;
      rd_check(`VCS_ADDR_PORT_CFG, 8'h0d);
      check_byte({6'h00, link.logic_output_zero, link.logic_output_one}, 8'h03);
      wr(`VCS_ADDR_PORT_CFG, 8'h13);
      i_dout_sel = `VCS_SEL_OUT_ONE;
      rd_check(`VCS_ADDR_PORT_CFG, 8'h13);
      check_byte({6'h00, link.pump, link.logic_output_zero}, 8'h02);
      wr(`VCS_ADDR_PORT_CFG, 8'h02);
      i_dout_sel = `VCS_SEL_OUT_ZERO;
      wr(`VCS_ADDR_MAP_PTR, 8'h05);
      wr(`VCS_ADDR_MAP_DATA, 8'h3c);
      rd_check(`VCS_ADDR_MAP_DATA, 8'h3c);
      wr(`VCS_ADDR_CFG, c | 8'h02);
      check_byte({7'h00, o_lock}, 8'h01);
      wr(`VCS_ADDR_GRIDS, ~g);
      wr(`VCS_ADDR_SHIFT_LIMIT, ~s);
      check_byte(o_grids, g);
      check_byte(o_shift_limit, s);
      wr(`VCS_ADDR_MAP_DATA, 8'hc3);
      wr(`VCS_ADDR_MAP_PTR, 8'h02);
      rd_check(`VCS_ADDR_MAP_PTR, 8'h02);
      wr(`VCS_ADDR_MAP_PTR, 8'h05);
      rd_check(`VCS_ADDR_MAP_DATA, 8'h3c);
      rd_check(`VCS_ADDR_GRIDS, g);
      wr(`VCS_ADDR_CFG, 8'h10);
      check_byte(8'(restarts), 8'h01);
      check_byte({7'h00, o_lock}, 8'h00);
      mux_pulses(7);
      check_byte({7'h00, o_blink_first_half}, 8'h01);
      mux_pulses(1);
      check_byte({7'h00, o_blink_first_half}, 8'h00);
      rd_check(`VCS_ADDR_CFG, 8'h10);
      wr(`VCS_ADDR_CFG, 8'h14);
      check_byte(8'(restarts), 8'h02);
      check_byte({7'h00, o_blink_first_half}, 8'h01);
      mux_pulses(3);
      check_byte({7'h00, o_blink_first_half}, 8'h01);
      mux_pulses(1);
      check_byte({7'h00, o_blink_first_half}, 8'h00);
      wr(`VCS_ADDR_CFG, 8'h04);
      check_byte({7'h00, o_blink_first_half}, 8'h00);
      // second reset in mid-run: pins low, phase and registers back to reset
      i_sys_rst = 1'b1;
      repeat (3) @(negedge i_clk);
      i_sys_rst = 1'b0;
      check_byte({7'h00, link.logic_output_zero}, 8'h00);
      check_byte({7'h00, o_blink_first_half}, 8'h01);
      wr(`VCS_ADDR_PORT_CFG, 8'h02);
      rd_check(`VCS_ADDR_GRIDS, 8'h00);
      summarize();
   end
endmodule
